// ==== rtl/qtd_frame_dma.sv ====
// Table-driven frame DMA engine: pixel stream in, address/data writes out.
// Assumes a same-clock pixel source and a same-clock bus write master
// that accepts one pixel write per cycle while dma_ready is high.
//
// What this block does
// - Table written by entry number, 0 to 32767
// - Two banks, starting at entries 0, 16384
// - One bank runs while host loads other
// - Bank change after last end-of-transfer descriptor
// - Descriptor gives destination and pixel count
// - Looped table transfers every frame continuously
// - End-of-chain stops after frame's final pixel
// - Cleared end-of-chain resumes same table looping
// - Interrupt-flagged descriptor signals host on completion
// - Every pixel moved off board, none skipped
// - Pixels through lookup bank 0, 1, bypass
// - Any physical destination address is accepted
// - Host may write any single table location
`timescale 1ns/1ps
module qtd_frame_dma #(
  parameter int ENTRIES = qtd_pkg::TABLE_ENTRIES,
  parameter int LUT_AW = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [qtd_pkg::AVM_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic pix_valid,
  input wire logic [qtd_pkg::PIX_W-1:0] pix_data,
  output logic pix_ready,
  output logic dma_valid,
  output logic [31:0] dma_addr,
  output logic [qtd_pkg::PIX_W-1:0] dma_data,
  output logic dma_to_display,
  input wire logic dma_ready,
  output logic desc_irq_pulse
);

  localparam int LUT_N = 1 << LUT_AW;
  localparam logic [qtd_pkg::ENT_AW-1:0] BASE1 = qtd_pkg::ENT_AW'(qtd_pkg::BANK1_BASE);

  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_XFER, ST_END, ST_DRAIN} qtd_state_t;

  typedef struct packed {
    qtd_state_t st;
    logic ack;
    logic [31:0] rdata;
    logic [qtd_pkg::ENT_AW-1:0] idx;
    logic bank;
    logic engage;
    logic chg_pend;
    logic [1:0] lut_sel;
    logic [1:0] lut_mode;
    logic [31:0] dst;
    logic [qtd_pkg::CNT_W-1:0] left;
    logic end_of_transfer_flag;
    logic eoc;
    logic irq;
    logic disp;
    logic done;
    logic ov;
    logic [31:0] oaddr;
    logic [qtd_pkg::PIX_W-1:0] odata;
    logic odisp;
    logic irq_p;
    logic [1:0][LUT_N-1:0][qtd_pkg::PIX_W-1:0] lut;
  } qtd_regs_t;

  qtd_regs_t state_reg;
  qtd_regs_t state_next;

  logic [qtd_pkg::ENTRY_W-1:0] eng_entry;
  logic [qtd_pkg::ENTRY_W-1:0] bus_entry;
  logic req;
  logic take;
  logic is_table;
  logic tbl_wr;
  logic [3:0] reg_sel;
  logic [31:0] wmask;
  logic [31:0] ctrl_val;
  logic [31:0] stat_val;
  logic accept;
  logic [qtd_pkg::PIX_W-1:0] mapped;

  // ==========================================================================
  // Bus slave decode: one wait cycle, then the access completes
  assign req = read | write;
  assign take = req & state_reg.ack;
  assign waitrequest = req & ~state_reg.ack;
  assign is_table = address[qtd_pkg::TABLE_SEL_BIT];
  assign reg_sel = address[3:0];
  assign tbl_wr = take & write & is_table;
  assign readdata = state_reg.rdata;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{byteenable[b]}};
    end
  end

  assign ctrl_val = {25'h0000000, state_reg.lut_mode, state_reg.lut_sel,
                     state_reg.chg_pend, state_reg.engage, 1'b0};
  assign stat_val = {28'h0000000, state_reg.done, state_reg.chg_pend, state_reg.bank,
                     state_reg.st != ST_IDLE};

  qtd_desc_table #(
    .ENTRIES(ENTRIES)
  ) u_table (
    .clock(clock),
    .resetn(resetn),
    .wr_en(tbl_wr),
    .wr_index(address[qtd_pkg::ENT_AW:1]),
    .wr_word(address[0]),
    .wr_data(writedata),
    .wr_be(byteenable),
    .eng_index(state_reg.idx),
    .eng_entry(eng_entry),
    .bus_index(address[qtd_pkg::ENT_AW:1]),
    .bus_entry(bus_entry)
  );

  // ==========================================================================
  // Pixel mapping through the selected lookup bank
  function automatic logic [qtd_pkg::PIX_W-1:0] lut_index(
    input logic [qtd_pkg::PIX_W-1:0] p,
    input logic [1:0] mode
  );
    logic [qtd_pkg::PIX_W-1:0] r;
    r = '0;
    unique case (mode)
      qtd_pkg::lookup_mode_8: r = {8'h00, p[7:0]} >> (8 - LUT_AW);
      qtd_pkg::lookup_mode_12: r = {4'h0, p[11:0]} >> (12 - LUT_AW);
      default: r = p >> (16 - LUT_AW);
    endcase
    return r;
  endfunction : lut_index

  always_comb begin
    logic [qtd_pkg::PIX_W-1:0] li;
    li = lut_index(pix_data, state_reg.lut_mode);
    unique case (state_reg.lut_sel)
      qtd_pkg::lookup_bank_zero: mapped = state_reg.lut[0][li[LUT_AW-1:0]];
      qtd_pkg::lookup_bank_one: mapped = state_reg.lut[1][li[LUT_AW-1:0]];
      default: mapped = pix_data;
    endcase
  end

  // A pixel is taken only when the output register can hold it, so
  // back-pressure from the bus stalls the source rather than losing data.
  assign pix_ready = (state_reg.st == ST_XFER) && (!state_reg.ov || dma_ready);
  assign accept = pix_ready & pix_valid;

  assign dma_valid = state_reg.ov;
  assign dma_addr = state_reg.oaddr;
  assign dma_data = state_reg.odata;
  assign dma_to_display = state_reg.odisp;
  assign desc_irq_pulse = state_reg.irq_p;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic [31:0] mw;
    logic start;
    logic chg_set;
    logic done_clr;
    state_next = state_reg;
    mw = writedata & wmask;
    start = 1'b0;
    chg_set = 1'b0;
    done_clr = 1'b0;
    state_next.irq_p = 1'b0;

    // Bus access handshake and register effects
    state_next.ack = req & ~state_reg.ack;
    if (req && !state_reg.ack) begin
      state_next.rdata = '0;
      if (read && is_table) begin
        state_next.rdata = address[0] ? bus_entry[63:32] : bus_entry[31:0];
      end else if (read) begin
        unique case (reg_sel)
          qtd_pkg::REG_CTRL: state_next.rdata = ctrl_val;
          qtd_pkg::REG_STATUS: state_next.rdata = stat_val;
          qtd_pkg::REG_INDEX: state_next.rdata = 32'(state_reg.idx);
          default: state_next.rdata = '0;
        endcase
      end
    end
    if (take && write && !is_table) begin
      unique case (reg_sel)
        qtd_pkg::REG_CTRL: begin
          start = mw[qtd_pkg::CTRL_START];
          chg_set = mw[qtd_pkg::CTRL_CHANGE];
          if (byteenable[0]) begin
            state_next.engage = writedata[qtd_pkg::CTRL_BANK];
            state_next.lut_sel = writedata[qtd_pkg::CTRL_LSEL +: 2];
            state_next.lut_mode = writedata[qtd_pkg::CTRL_LMODE +: 2];
          end
        end
        qtd_pkg::REG_STATUS: done_clr = mw[qtd_pkg::STAT_DONE];
        qtd_pkg::REG_LUT: begin
          if (&byteenable) begin
            state_next.lut[writedata[qtd_pkg::LUTW_BANK]]
              [writedata[qtd_pkg::LUTW_INDEX +: LUT_AW]] = writedata[qtd_pkg::LUTW_DATA +: 16];
          end
        end
        default: ;
      endcase
    end
    if (done_clr) begin
      state_next.done = 1'b0;
    end

    // Output register drains whenever the bus master takes it
    if (state_reg.ov && dma_ready) begin
      state_next.ov = 1'b0;
    end
    if (accept) begin
      state_next.ov = 1'b1;
      state_next.oaddr = state_reg.dst;
      state_next.odata = mapped;
      state_next.odisp = state_reg.disp;
      state_next.dst = state_reg.dst + qtd_pkg::PIX_BYTES;
      state_next.left = state_reg.left - 1'b1;
    end

    // Descriptor walk
    unique case (state_reg.st)
      ST_IDLE: begin
        if (start) begin
          // Engage decides the bank; the host must not change it mid-run
          state_next.bank = state_reg.engage;
          state_next.idx = state_reg.engage ? BASE1 : '0;
          state_next.st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_next.dst = eng_entry[31:0];
        state_next.left = eng_entry[32 + qtd_pkg::CNT_LSB +: qtd_pkg::CNT_W];
        state_next.end_of_transfer_flag = eng_entry[32 + qtd_pkg::EOX_BIT];
        state_next.eoc = eng_entry[32 + qtd_pkg::EOC_BIT];
        state_next.irq = eng_entry[32 + qtd_pkg::IRQ_BIT];
        state_next.disp = eng_entry[32 + qtd_pkg::DISP_BIT];
        state_next.st = (eng_entry[32 +: qtd_pkg::CNT_W] == '0) ? ST_END : ST_XFER;
      end
      ST_XFER: begin
        if (accept && state_reg.left == qtd_pkg::CNT_W'(1)) begin
          state_next.st = ST_END;
        end
      end
      ST_END: begin
        state_next.irq_p = state_reg.irq;
        if (!state_reg.end_of_transfer_flag) begin
          state_next.idx = state_reg.idx + 1'b1;
          state_next.st = ST_LOAD;
        end else if (state_reg.eoc) begin
          state_next.st = ST_DRAIN;
        end else if (state_reg.chg_pend) begin
          // Switch only here, never inside a descriptor
          state_next.bank = ~state_reg.bank;
          state_next.idx = state_reg.bank ? '0 : BASE1;
          state_next.chg_pend = 1'b0;
          state_next.st = ST_LOAD;
        end else begin
          // Re-read the bank from its base; a cleared end-of-chain loops on
          state_next.idx = state_reg.bank ? BASE1 : '0;
          state_next.st = ST_LOAD;
        end
      end
      ST_DRAIN: begin
        // Stop only once the final pixel has left the output register
        if (!state_reg.ov || dma_ready) begin
          state_next.done = 1'b1;
          state_next.st = ST_IDLE;
        end
      end
    endcase

    // A request arriving with the switch still stays pending
    if (chg_set) begin
      state_next.chg_pend = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : qtd_frame_dma

// ==== pkg/qtd_pkg.sv ====
// Constants shared by the frame DMA engine and its descriptor table.
// Assumes a 32-bit Avalon-MM slave port with word addressing.
package qtd_pkg;

  // ==========================================================================
  // Descriptor table geometry
  localparam int ENT_AW = 15;
  localparam int TABLE_ENTRIES = 32768;
  localparam int BANK1_BASE = 16384;
  localparam int ENTRY_W = 64;

  // ==========================================================================
  // Descriptor entry layout (word 0 destination, word 1 count and flags)
  localparam int CNT_LSB = 0;
  localparam int CNT_W = 16;
  localparam int EOX_BIT = 16;
  localparam int EOC_BIT = 17;
  localparam int IRQ_BIT = 18;
  localparam int DISP_BIT = 19;

  // ==========================================================================
  // Avalon address map (word addresses)
  localparam int AVM_AW = 17;
  localparam int TABLE_SEL_BIT = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_LUT = 4'h2;
  localparam logic [3:0] REG_INDEX = 4'h3;

  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_BANK = 1;
  localparam int CTRL_CHANGE = 2;
  localparam int CTRL_LSEL = 3;
  localparam int CTRL_LMODE = 5;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_BANK = 1;
  localparam int STAT_PEND = 2;
  localparam int STAT_DONE = 3;

  // Lookup write register fields
  localparam int LUTW_DATA = 0;
  localparam int LUTW_INDEX = 16;
  localparam int LUTW_BANK = 24;

  // ==========================================================================
  // Pixel path
  localparam int PIX_W = 16;
  localparam logic [31:0] PIX_BYTES = 32'h0000_0002;
  localparam logic [1:0] lookup_bank_zero = 2'h0;
  localparam logic [1:0] lookup_bank_one = 2'h1;
  localparam logic [1:0] lookup_bypass = 2'h2;
  localparam logic [1:0] lookup_mode_8 = 2'h0;
  localparam logic [1:0] lookup_mode_12 = 2'h1;
  localparam logic [1:0] lookup_mode_16 = 2'h2;

endpackage : qtd_pkg

// ==== rtl/qtd_desc_table.sv ====
// Descriptor table storage: one write port with byte enables, two read ports.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/1ps
module qtd_desc_table #(
  parameter int ENTRIES = qtd_pkg::TABLE_ENTRIES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [qtd_pkg::ENT_AW-1:0] wr_index,
  input wire logic wr_word,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  input wire logic [qtd_pkg::ENT_AW-1:0] eng_index,
  output logic [qtd_pkg::ENTRY_W-1:0] eng_entry,
  input wire logic [qtd_pkg::ENT_AW-1:0] bus_index,
  output logic [qtd_pkg::ENTRY_W-1:0] bus_entry
);

  typedef struct packed {
    logic [ENTRIES-1:0][qtd_pkg::ENTRY_W-1:0] mem;
  } qtd_table_t;

  qtd_table_t state_reg;
  qtd_table_t state_next;

  // ==========================================================================
  // Any single entry may be written; no bank-aligned bulk load needed
  always_comb begin
    state_next = state_reg;
    if (wr_en && (32'(wr_index) < ENTRIES)) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_be[b]) begin
          state_next.mem[wr_index][{wr_word, 5'(b * 8)} +: 8] = wr_data[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Out-of-range indices read as zero, a zero-count descriptor
  assign eng_entry = (32'(eng_index) < ENTRIES) ? state_reg.mem[eng_index] : '0;
  assign bus_entry = (32'(bus_index) < ENTRIES) ? state_reg.mem[bus_index] : '0;

endmodule : qtd_desc_table

// ==== test/qtd_assertions.sv ====
// Port checks for the frame DMA engine.
// Assumes binding onto qtd_frame_dma, one clock domain.
`timescale 1ns/1ps
module qtd_assertions #(
  parameter int ENTRIES = 64,
  parameter int LUT_AW = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic dma_valid,
  input wire logic [31:0] dma_addr,
  input wire logic [qtd_pkg::PIX_W-1:0] dma_data,
  input wire logic dma_to_display,
  input wire logic dma_ready,
  input wire logic desc_irq_pulse
);
  // ========
  // Helpers
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic take = pix_valid && pix_ready;
  wire logic stall = dma_valid && !dma_ready;
  sequence one_wait; waitrequest ##1 !waitrequest; endsequence
  sequence two_quiet; !pix_ready ##1 !pix_ready; endsequence
  sequence two_takes; take ##1 take; endsequence
  // ========
  // Checks
  chk_bus_wait: assert property ($rose(read || write) |-> one_wait)
    else $error("bus wait not one cycle");
  chk_pix_out: assert property (take |=> dma_valid)
    else $error("taken pixel not issued");
  chk_out_hold: assert property (stall |=> dma_valid && $stable(dma_addr)
    && $stable(dma_data) && $stable(dma_to_display))
    else $error("stalled write changed");
  chk_stall_block: assert property (stall |-> !pix_ready)
    else $error("pixel taken while stalled");
  chk_addr_step: assert property (two_takes |=> dma_addr == $past(dma_addr) + 32'h2)
    else $error("address step not two bytes");
  chk_irq_single: assert property (desc_irq_pulse |=> !desc_irq_pulse)
    else $error("irq pulse too long");
  chk_irq_gap: assert property (desc_irq_pulse |-> !pix_ready && !$past(pix_ready))
    else $error("irq outside descriptor end");
  chk_desc_gap: assert property ($fell(pix_ready) && !stall |-> two_quiet)
    else $error("descriptor gap too short");
endmodule : qtd_assertions

bind qtd_frame_dma qtd_assertions #(.ENTRIES(ENTRIES), .LUT_AW(LUT_AW)) chk (.clock(clock),
  .resetn(resetn), .read(read), .write(write), .waitrequest(waitrequest),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .dma_valid(dma_valid), .dma_addr(dma_addr),
  .dma_data(dma_data), .dma_to_display(dma_to_display), .dma_ready(dma_ready),
  .desc_irq_pulse(desc_irq_pulse));

// ==== test/qtd_host_mem.sv ====
// Host memory write target behind the bus master.
// Assumes the engine holds each write until accepted.
`timescale 1ns/1ps
module qtd_host_mem (
  input wire logic clock,
  input wire logic resetn,
  input wire logic slow,
  output logic dma_ready
);
  logic [1:0] cnt_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  end
  // Any address is accepted; slow mode takes one write in four like a busy target
  assign dma_ready = !slow || (cnt_reg == 2'h0);
endmodule : qtd_host_mem

// ==== test/qtd_frame_dma_bench.sv ====
// Self-checking bench for the frame DMA engine.
// Assumes qtd_host_mem as write target and a 16400-entry table.
`timescale 1ns/1ps
module qtd_frame_dma_bench;
  // ========
  // Signals
  localparam logic [31:0] END_OF_TRANSFER_FLAG = 32'h1 << qtd_pkg::EOX_BIT;
  localparam logic [31:0] EOC = 32'h1 << qtd_pkg::EOC_BIT;
  localparam logic [31:0] IRQ = 32'h1 << qtd_pkg::IRQ_BIT;
  localparam logic [31:0] CB = (32'h2 << qtd_pkg::CTRL_LSEL) | (32'h2 << qtd_pkg::CTRL_LMODE);
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [16:0] address = 17'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] be = 4'hF;
  logic pix_valid = 1'b0;
  logic [15:0] pix_data = 16'h0;
  logic slow = 1'b0;
  logic [31:0] readdata, dma_addr, q;
  logic waitrequest, pix_ready, dma_valid, dma_to_display, dma_ready, desc_irq_pulse;
  logic [15:0] dma_data;
  logic [15:0] seed = 16'h6;
  logic [48:0] expq[$];
  logic [48:0] got;
  int errors = 0;
  int checked = 0;
  int irqs = 0;
  always #50 clock = ~clock;
  qtd_frame_dma #(.ENTRIES(16400), .LUT_AW(8)) uut (.clock(clock), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
    .dma_valid(dma_valid), .dma_addr(dma_addr), .dma_data(dma_data),
    .dma_to_display(dma_to_display), .dma_ready(dma_ready), .desc_irq_pulse(desc_irq_pulse));
  qtd_host_mem host (.clock(clock), .resetn(resetn), .slow(slow), .dma_ready(dma_ready));
  // ========
  // Tasks
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic give_verdict;
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [48:0] seen, input logic [48:0] want, input string what);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [16:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    // Request stands until the edge that samples waitrequest low
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        errors++;
        give_verdict();
      end
      @(posedge clock);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [16:0] a, input logic [31:0] want, input string what);
    bus(1'b0, a, 32'h0);
    check({17'h0, q}, {17'h0, want}, what);
  endtask : rd_chk
  task automatic entry(input int e, input logic [31:0] dest, input logic [31:0] w1);
    bus(1'b1, {1'b1, e[14:0], 1'b0}, dest);
    bus(1'b1, {1'b1, e[14:0], 1'b1}, w1);
  endtask : entry
  task automatic wait_idle;
    int n;
    n = 0;
    q = 32'h1;
    while (q[qtd_pkg::STAT_BUSY] !== 1'b0) begin
      n++;
      if (n > 60) begin
        errors++;
        give_verdict();
      end
      bus(1'b0, 17'h1, 32'h0);
    end
  endtask : wait_idle
  // Lookup selections use a fixed pixel; bypass uses a fresh random one
  task automatic seg(input logic [31:0] dest, input int cnt, input logic disp,
    input logic [1:0] sel, input logic [15:0] fix);
    int n;
    logic [15:0] p;
    for (int i = 0; i < cnt; i++) begin
      seed = lfsr(seed);
      p = (sel == 2'h2) ? seed : fix;
      expq.push_back({disp, dest + 32'(2 * i),
        (sel == 2'h0) ? 16'h1234 : (sel == 2'h1) ? 16'hBEEF : p});
      pix_valid <= 1'b1;
      pix_data <= p;
      n = 0;
      @(posedge clock);
      while (pix_ready !== 1'b1) begin
        n++;
        if (n > 200) begin
          errors++;
          give_verdict();
        end
        @(posedge clock);
      end
    end
  endtask : seg
  // ========
  // Output watcher
  always @(posedge clock) begin
    if (resetn && dma_valid === 1'b1 && dma_ready === 1'b1) begin
      got = (expq.size() > 0) ? expq.pop_front() : ~{dma_to_display, dma_addr, dma_data};
      check({dma_to_display, dma_addr, dma_data}, got, "dma write");
    end
    if (desc_irq_pulse === 1'b1) irqs++;
  end
  // ========
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rd_chk(17'h1, 32'h0, "status");
    rd_chk(17'h4, 32'h0, "unmapped");
    entry(0, 32'h1000_0000, 32'h3);
    entry(1, 32'h2000_0000, 32'h2 | END_OF_TRANSFER_FLAG | IRQ | (32'h1 << qtd_pkg::DISP_BIT));
    entry(16399, 32'hCAFE_0000, 32'h0);
    rd_chk({1'b1, 15'h400F, 1'b0}, 32'hCAFE_0000, "table");
    bus(1'b1, 17'h0, CB | 32'h1);
    seg(32'h1000_0000, 3, 1'b0, 2'h2, 16'h0);
    seg(32'h2000_0000, 2, 1'b1, 2'h2, 16'h0);
    seg(32'h1000_0000, 1, 1'b0, 2'h2, 16'h0);
    pix_valid <= 1'b0;
    slow <= 1'b1;
    entry(16384, 32'h3000_0000, 32'h4 | END_OF_TRANSFER_FLAG | EOC | IRQ);
    bus(1'b1, 17'h0, CB | (32'h1 << qtd_pkg::CTRL_CHANGE));
    rd_chk(17'h1, 32'h5, "status pending");
    rd_chk(17'h0, 32'h54, "control");
    seg(32'h1000_0002, 2, 1'b0, 2'h2, 16'h0);
    seg(32'h2000_0000, 2, 1'b1, 2'h2, 16'h0);
    seg(32'h3000_0000, 4, 1'b0, 2'h2, 16'h0);
    pix_valid <= 1'b0;
    wait_idle();
    rd_chk(17'h1, 32'hA, "status stopped");
    rd_chk(17'h3, 32'h4000, "entry index");
    check(49'(irqs), 49'h3, "irq count");
    bus(1'b1, 17'h1, 32'h8);
    rd_chk(17'h1, 32'h2, "status cleared");
    slow <= 1'b0;
    bus(1'b1, 17'h2, {7'h0, 1'b0, 8'h5A, 16'h1234});
    bus(1'b1, 17'h2, {7'h0, 1'b1, 8'h5A, 16'hBEEF});
    // Partial lane write to the lookup must be refused
    be <= 4'h7;
    bus(1'b1, 17'h2, {7'h0, 1'b0, 8'h5A, 16'hDEAD});
    be <= 4'hF;
    // Engage bank 1 on its own before any start
    bus(1'b1, 17'h0, 32'h2);
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 3; m++) begin
        bus(1'b1, 17'h0, 32'h3 | (32'(s) << 3) | (32'(m) << 5));
        seg(32'h3000_0000, 4, 1'b0, 2'(s), 16'(16'h5A << (4 * m)));
        pix_valid <= 1'b0;
        wait_idle();
      end
    end
    check(49'(irqs), 49'h9, "irq count");
    bus(1'b1, {1'b1, 15'h4000, 1'b1}, 32'h4 | END_OF_TRANSFER_FLAG | IRQ);
    bus(1'b1, 17'h0, CB | 32'h3);
    seg(32'h3000_0000, 4, 1'b0, 2'h2, 16'h0);
    seg(32'h3000_0000, 4, 1'b0, 2'h2, 16'h0);
    pix_valid <= 1'b0;
    rd_chk(17'h1, 32'hB, "status looping");
    check(49'(expq.size()), 49'h0, "writes left");
    give_verdict();
  end
endmodule : qtd_frame_dma_bench
